/* rtl/imuv_pkg.sv */
// Constants for the velocity-change and rate-offset register bank.
// Assumes a 25 MHz core clock and a 16-bit register port at byte offsets.
package imuv_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 16;
  localparam int          WORD_W        = 32;
  localparam int          ACC_W         = 48;
  localparam int          CNT_W         = 16;
  localparam int          SYNC_W        = 3;

  // Register byte offsets
  localparam logic [7:0]  Y_VEL_LOW_OFS = 8'h34;
  localparam logic [7:0]  Y_VEL_HIGH_OFS = 8'h36;
  localparam logic [7:0]  Z_VEL_LOW_OFS = 8'h38;
  localparam logic [7:0]  Z_VEL_HIGH_OFS = 8'h3A;
  localparam logic [7:0]  X_RATE_LOW_OFS = 8'h40;
  localparam logic [7:0]  X_RATE_HIGH_OFS = 8'h42;
  localparam logic [7:0]  Y_RATE_LOW_OFS = 8'h44;
  localparam logic [7:0]  Y_RATE_HIGH_OFS = 8'h46;
  localparam logic [7:0]  DEC_SET_OFS   = 8'h64;
  localparam logic [7:0]  CHAIN_STAT_OFS = 8'h66;

  // Reset values and unmapped read value
  localparam logic [15:0] RATE_OFS_RST  = 16'h0000;
  localparam logic [15:0] DEC_SET_RST   = 16'h0000;
  localparam logic [15:0] UNMAPPED_VAL  = 16'h0000;

  // Chain status field positions
  localparam int          STAT_SRC_BIT  = 15;
  localparam int          STAT_CNT_MSB  = 14;

  // Velocity scaling: full scale 400 m/sec at code 0x8000 / 0x80000000
  localparam int          VEL_RANGE_MPS = 400;
  localparam logic [31:0] VEL_MAX_POS   = 32'h7FFFFFFF;
  localparam logic [31:0] VEL_MAX_NEG   = 32'h80000000;
  // Halving of the trapezoid pair sum (the 1/(2 fs) term, fs folded into input scale)
  localparam int          TRAP_SHIFT    = 1;

  // Sample timing
  localparam int          CORE_CLK_HZ   = 25_000_000;
  localparam int          SAMPLE_HZ     = 2000;
  localparam int          SAMPLE_DIV    = CORE_CLK_HZ / SAMPLE_HZ;
endpackage

/* rtl/imuv_regs.sv */
// Velocity-change outputs, rate-offset correction and their register port.
// Assumes factory-corrected samples arrive on the core clock; the external
// sample strobe is asynchronous and is synchronised here.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps

module imuv_regs #(
  parameter int SAMPLE_DIV = imuv_pkg::SAMPLE_DIV
) (
  input  wire logic        core_clk,        // 25 MHz core clock
  input  wire logic        rst_b,           // Async reset, active low
  input  wire logic [7:0]  reg_addr,        // Register byte address
  input  wire logic [15:0] reg_wdata,       // Register write data
  input  wire logic        reg_wr,          // Write strobe
  input  wire logic        reg_rd,          // Read strobe
  output logic      [15:0] reg_rdata,       // Read data, cycle after strobe
  input  wire logic        ext_sample_sel,  // High: external sample strobe
  input  wire logic        ext_sample,      // External sample pin
  input  wire logic [31:0] gyro_x_fact,     // Factory-corrected x rate
  input  wire logic [31:0] gyro_y_fact,     // Factory-corrected y rate
  input  wire logic [31:0] accel_y_fact,    // Factory-corrected y accel
  input  wire logic [31:0] accel_z_fact,    // Factory-corrected z accel
  output logic      [31:0] gyro_x_corr,     // Offset-corrected x rate
  output logic      [31:0] gyro_y_corr,     // Offset-corrected y rate
  output logic             sample_tick,     // One pulse per chain sample
  output logic             vel_update       // One pulse per velocity update
);

  localparam int NG = 2;
  localparam int NA = 2;
  localparam int DIV_W = $clog2(SAMPLE_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);

  // Sample rate divider and external strobe

  logic [DIV_W-1:0]  div_cnt_r;
  logic              int_tick;
  logic [2:0]        ext_sync_r;
  logic              ext_level_r;
  logic              ext_tick;
  logic [2:0]        sel_sync_r;
  logic              sel_level_r;
  logic              sel_chg;
  logic              tick;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_r <= '0;
    end else if (sel_chg || div_cnt_r == DIV_LAST) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + DIV_W'(1);
    end
  end

  assign int_tick = (div_cnt_r == DIV_LAST);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_sync_r <= 3'h0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], ext_sample};
    end
  end

  // Level accepted only when stages two and three agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_level_r <= 1'b0;
    end else if (ext_sync_r[1] == ext_sync_r[2]) begin
      ext_level_r <= ext_sync_r[2];
    end
  end

  assign ext_tick = (ext_sync_r[1] == ext_sync_r[2]) && ext_sync_r[2] && !ext_level_r;

  // Source select is a pin as well, filtered the same way
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_sync_r <= 3'h0;
    end else begin
      sel_sync_r <= {sel_sync_r[1:0], ext_sample_sel};
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_level_r <= 1'b0;
    end else if (sel_sync_r[1] == sel_sync_r[2]) begin
      sel_level_r <= sel_sync_r[2];
    end
  end

  // Restarting the divider on a source switch avoids one short period
  assign sel_chg = (sel_sync_r[1] == sel_sync_r[2]) && (sel_sync_r[2] != sel_level_r);

  // Unsynchronised select never reaches the chain; a glitch could split a tick
  assign tick     = sel_level_r ? ext_tick : int_tick;

  // Register storage

  logic [15:0] rate_low_r  [NG];
  logic [15:0] rate_high_r [NG];
  logic [15:0] dec_set_r;
  logic [31:0] vel_r       [NA];
  logic [15:0] vel_hold_r  [NA];
  logic [15:0] dec_cnt_r;

  // Gyro offset words and correction
  genvar g;
  generate
    for (g = 0; g < NG; g++) begin : g_gyro
      localparam logic [7:0] LOW_OFS  = (g == 0) ? imuv_pkg::X_RATE_LOW_OFS
                                                 : imuv_pkg::Y_RATE_LOW_OFS;
      localparam logic [7:0] HIGH_OFS = (g == 0) ? imuv_pkg::X_RATE_HIGH_OFS
                                                 : imuv_pkg::Y_RATE_HIGH_OFS;
      logic [31:0] fact;
      logic [31:0] ofs;
      logic [32:0] sum;
      logic [31:0] sat;

      assign fact = (g == 0) ? gyro_x_fact : gyro_y_fact;
      assign ofs  = {rate_high_r[g], rate_low_r[g]};

      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          rate_low_r[g] <= imuv_pkg::RATE_OFS_RST;
        end else if (reg_wr && reg_addr == LOW_OFS) begin
          rate_low_r[g] <= reg_wdata;
        end
      end

      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          rate_high_r[g] <= imuv_pkg::RATE_OFS_RST;
        end else if (reg_wr && reg_addr == HIGH_OFS) begin
          rate_high_r[g] <= reg_wdata;
        end
      end

      // Offset sits directly behind the factory stage
      assign sum = {fact[31], fact} + {ofs[31], ofs};
      assign sat = (sum[32] != sum[31]) ?
                   (sum[32] ? imuv_pkg::VEL_MAX_NEG : imuv_pkg::VEL_MAX_POS) :
                   sum[31:0];

      // One process per output, so each output has a single driver
      if (g == 0) begin : g_x
        always_ff @(posedge core_clk or negedge rst_b) begin
          if (!rst_b) begin
            gyro_x_corr <= 32'h00000000;
          end else if (tick) begin
            gyro_x_corr <= sat;
          end
        end
      end else begin : g_y
        always_ff @(posedge core_clk or negedge rst_b) begin
          if (!rst_b) begin
            gyro_y_corr <= 32'h00000000;
          end else if (tick) begin
            gyro_y_corr <= sat;
          end
        end
      end
    end
  endgenerate

  // Decimation setting and interval counter

  logic dec_end;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_set_r <= imuv_pkg::DEC_SET_RST;
    end else if (reg_wr && reg_addr == imuv_pkg::DEC_SET_OFS) begin
      dec_set_r <= reg_wdata;
    end
  end

  assign dec_end = (dec_cnt_r >= dec_set_r);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_cnt_r <= '0;
    end else if (tick) begin
      dec_cnt_r <= dec_end ? 16'h0000 : dec_cnt_r + 16'h0001;
    end
  end

  // Velocity-change integration per accel axis
  genvar a;
  generate
    for (a = 0; a < NA; a++) begin : g_vel
      localparam logic [7:0] LOW_OFS = (a == 0) ? imuv_pkg::Y_VEL_LOW_OFS
                                                : imuv_pkg::Z_VEL_LOW_OFS;
      logic [31:0]                   cur;
      logic [31:0]                   prev_r;
      logic [imuv_pkg::ACC_W-1:0]    acc_r;
      logic [imuv_pkg::ACC_W-1:0]    pair;
      logic [imuv_pkg::ACC_W-1:0]    total;
      logic [imuv_pkg::ACC_W-1:0]    scaled;
      logic [31:0]                   sat;

      assign cur    = (a == 0) ? accel_y_fact : accel_z_fact;
      assign pair   = imuv_pkg::ACC_W'($signed(cur)) + imuv_pkg::ACC_W'($signed(prev_r));
      assign total  = acc_r + pair;
      assign scaled = $signed(total) >>> imuv_pkg::TRAP_SHIFT;
      // Clip at the 32-bit limits so -400 m/sec stays 0x80000000
      assign sat = ($signed(scaled) > $signed({16'h0000, imuv_pkg::VEL_MAX_POS})) ?
                   imuv_pkg::VEL_MAX_POS :
                   ($signed(scaled) < $signed({16'hFFFF, imuv_pkg::VEL_MAX_NEG})) ?
                   imuv_pkg::VEL_MAX_NEG : scaled[31:0];

      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          prev_r <= 32'h00000000;
        end else if (tick) begin
          prev_r <= cur;
        end
      end

      // Cleared as the interval closes; the closing pair goes to the output
      // through total, so no sample is lost across the boundary
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          acc_r <= '0;
        end else if (tick) begin
          acc_r <= dec_end ? '0 : total;
        end
      end

      // Both halves come from one 32-bit register
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          vel_r[a] <= 32'h00000000;
        end else if (tick && dec_end) begin
          vel_r[a] <= sat;
        end
      end

      // Reading the low word freezes the matching high word
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          vel_hold_r[a] <= 16'h0000;
        end else if (reg_rd && reg_addr == LOW_OFS) begin
          vel_hold_r[a] <= vel_r[a][31:16];
        end
      end
    end
  endgenerate

  // Status pulses

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= tick;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      vel_update <= 1'b0;
    end else begin
      vel_update <= tick && dec_end;
    end
  end

  // Status word built from the package field positions
  logic [15:0] stat_word;

  always_comb begin
    stat_word = 16'h0000;
    stat_word[imuv_pkg::STAT_SRC_BIT] = sel_level_r;
    stat_word[imuv_pkg::STAT_CNT_MSB:0] = dec_cnt_r[imuv_pkg::STAT_CNT_MSB:0];
  end

  // Read mux; factory terms have no address at all
  logic [15:0] rd_nxt;

  always_comb begin
    rd_nxt = imuv_pkg::UNMAPPED_VAL;
    case (reg_addr)
      imuv_pkg::Y_VEL_LOW_OFS:   rd_nxt = vel_r[0][15:0];
      imuv_pkg::Y_VEL_HIGH_OFS:  rd_nxt = vel_hold_r[0];
      imuv_pkg::Z_VEL_LOW_OFS:   rd_nxt = vel_r[1][15:0];
      imuv_pkg::Z_VEL_HIGH_OFS:  rd_nxt = vel_hold_r[1];
      imuv_pkg::X_RATE_LOW_OFS:  rd_nxt = rate_low_r[0];
      imuv_pkg::X_RATE_HIGH_OFS: rd_nxt = rate_high_r[0];
      imuv_pkg::Y_RATE_LOW_OFS:  rd_nxt = rate_low_r[1];
      imuv_pkg::Y_RATE_HIGH_OFS: rd_nxt = rate_high_r[1];
      imuv_pkg::DEC_SET_OFS:     rd_nxt = dec_set_r;
      imuv_pkg::CHAIN_STAT_OFS:  rd_nxt = stat_word;
      default:                   rd_nxt = imuv_pkg::UNMAPPED_VAL;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

/* sim/imuv_regs_asserts.sv */
// Assertions on the register port, sample chain and velocity strobes.
// Assumes one core clock domain; tick spacing is checked on the internal source.
`timescale 1ns/1ps
module imuv_regs_chk #(
  parameter int SAMPLE_DIV = 8
) (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        ext_sample_sel,
  input wire logic        ext_sample,
  input wire logic [31:0] gyro_x_fact,
  input wire logic [31:0] gyro_y_fact,
  input wire logic [31:0] accel_y_fact,
  input wire logic [31:0] accel_z_fact,
  input wire logic [31:0] gyro_x_corr,
  input wire logic [31:0] gyro_y_corr,
  input wire logic        sample_tick,
  input wire logic        vel_update
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] gap_r;
  logic        seen_r;

  // Cycles since the last chain sample
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_r  <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= sample_tick ? 16'h0000 : gap_r + 16'h0001;
      seen_r <= seen_r | sample_tick;
    end
  end

  a_tick_spacing: assert property (
    sample_tick && seen_r && !ext_sample_sel |-> gap_r == SAMPLE_DIV - 1)
    else $error("sample tick spacing wrong");
  a_tick_pulse: assert property (sample_tick |=> !sample_tick)
    else $error("sample tick longer than one cycle");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read");
  a_unmapped_zero: assert property (
    reg_rd && (reg_addr == 8'h48 || reg_addr[0]) |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_ofs_readback: assert property (
    reg_rd && $past(reg_wr) && reg_addr == $past(reg_addr) && reg_addr[7:3] == 5'h08
    && !reg_addr[0] |=> reg_rdata == $past(reg_wdata, 2))
    else $error("offset readback differs from write");
  a_corr_x_hold: assert property (!sample_tick |-> $stable(gyro_x_corr))
    else $error("x rate changed between samples");
  a_corr_y_hold: assert property (!sample_tick |-> $stable(gyro_y_corr))
    else $error("y rate changed between samples");
  a_vel_after_tick: assert property (
    vel_update |-> sample_tick)
    else $error("velocity update without a sample");
  a_vel_pulse: assert property (vel_update |=> !vel_update)
    else $error("velocity strobe longer than one cycle");
endmodule

bind imuv_regs imuv_regs_chk #(.SAMPLE_DIV(SAMPLE_DIV)) u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_sample_sel(ext_sample_sel),
  .ext_sample(ext_sample), .gyro_x_fact(gyro_x_fact), .gyro_y_fact(gyro_y_fact),
  .accel_y_fact(accel_y_fact), .accel_z_fact(accel_z_fact), .gyro_x_corr(gyro_x_corr),
  .gyro_y_corr(gyro_y_corr), .sample_tick(sample_tick), .vel_update(vel_update));

/* sim/imuv_host.sv */
// Host model driving the register port, noting each expected read value.
// Assumes tasks are entered right after a rising clock edge.
`timescale 1ns/1ps
module imuv_host (
  input  wire logic        core_clk,  // Core clock
  output logic      [7:0]  reg_addr,  // Byte address
  output logic      [15:0] reg_wdata, // Write data
  output logic             reg_wr,    // Write strobe
  output logic             reg_rd     // Read strobe
);
  logic [15:0] exp_q[$];

  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task automatic put(input logic w, input logic [7:0] a, input logic [15:0] d);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    put(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    put(1'b0, a, 16'h0000);
  endtask

  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
endmodule

/* sim/imuv_regs_tb_top.sv */
// Self-checking bench for the velocity-change and rate-offset registers.
// Assumes the host model drives the port and the checker is bound.
`timescale 1ns/1ps
module imuv_regs_tb_top;
  logic        core_clk, rst_b, rd_d, wr, rd, tick, vupd, esel, epin;
  int          n;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata;
  logic [15:0] o[4];
  logic [31:0] gx, gy, ay, az, cx, cy, ey, ez;
  int          miscompares, comparisons, cyc;

  always #20 core_clk = ~core_clk;

  imuv_host host (.core_clk(core_clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd));
  imuv_regs #(.SAMPLE_DIV(8)) uut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .ext_sample_sel(esel),
    .ext_sample(epin), .gyro_x_fact(gx), .gyro_y_fact(gy), .accel_y_fact(ay),
    .accel_z_fact(az), .gyro_x_corr(cx), .gyro_y_corr(cy), .sample_tick(tick),
    .vel_update(vupd));

  function automatic logic [31:0] sat(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] s;
    s = {a[31], a} + {b[31], b};
    sat = (s[32] != s[31]) ? (s[32] ? 32'h80000000 : 32'h7FFFFFFF) : s[31:0];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Waits for n velocity strobes
  task automatic wv(input int n);
    repeat (n) begin
      do @(posedge core_clk); while (vupd !== 1'b1);
    end
  endtask

  // Read results land in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_d) chk(32'(rdata), 32'(host.exp_q.pop_front()));
    rd_d <= rd;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    {core_clk, rst_b, rd_d, esel, epin} = 5'h0;
    {gx, gy, ay, az} = 128'h0;
    {miscompares, comparisons, cyc} = 96'h0;
    void'($urandom(32'hab22994f));
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 4; i++) host.rd(8'h40 + 8'(2 * i), 16'h0000);
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 4; i++) begin
        o[i] = r ? ((i == 0) ? 16'h0100 : 16'h0000) : 16'($urandom);
        host.wr(8'h40 + 8'(2 * i), o[i]);
        host.rd(8'h40 + 8'(2 * i), o[i]);
      end
      gx <= r ? 32'h7FFFFFF0 : $urandom;
      gy <= $urandom;
      host.idle();
      wv(2);
      chk(cx, sat(gx, {o[1], o[0]}));
      chk(cy, sat(gy, {o[3], o[2]}));
    end
    // Mid-run reset: offsets and corrected outputs return to zero
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk(cx, 32'h00000000);
    chk(cy, 32'h00000000);
    for (int i = 0; i < 4; i++) host.rd(8'h40 + 8'(2 * i), 16'h0000);
    for (int r = 0; r < 2; r++) begin
      host.wr(8'h64, 16'(r));
      ay <= r ? 32'h00001000 : 32'h80000000;
      az <= r ? 32'hFFFFF000 : 32'h7FFFFFFF;
      ey = r ? 32'h00002000 : 32'h80000000;
      ez = r ? 32'hFFFFE000 : 32'h7FFFFFFF;
      host.idle();
      wv(3);
      host.rd(8'h34, ey[15:0]);
      host.rd(8'h36, ey[31:16]);
      host.rd(8'h38, ez[15:0]);
      host.rd(8'h3A, ez[31:16]);
    end
    host.rd(8'h64, 16'h0001);
    host.idle();
    // External source: two rising pin edges give exactly two samples
    esel <= 1'b1;
    repeat (12) @(posedge core_clk);
    n = 0;
    repeat (2) begin
      epin <= 1'b1;
      repeat (10) begin
        @(posedge core_clk);
        n += int'(tick);
      end
      epin <= 1'b0;
      repeat (10) begin
        @(posedge core_clk);
        n += int'(tick);
      end
    end
    chk(32'(n), 32'h00000002);
    host.wr(8'h34, 16'hFFFF);
    host.wr(8'h48, 16'h5A5A);
    host.rd(8'h34, ey[15:0]);
    host.rd(8'h48, 16'h0000);
    host.rd(8'h41, 16'h0000);
    host.idle();
    repeat (2) @(posedge core_clk);
    end_sim();
  end
endmodule
